// File: verilog/strap_config_defines.vh
/*
  offsets, field positions, reset values and timing counts for the strap configuration latch.
  assumes plain verilog-2005 inclusion by bare name.
*/
`ifndef STRAP_CONFIG_DEFINES_VH
`define STRAP_CONFIG_DEFINES_VH

// register offsets
`define DISPLAY_ID_CONTROL_REG 8'h4f
`define VIDEO_BRIDGE_CONFIG_REG 8'h54
`define LINK_CONTROL_ONE_REG 8'h5b

// field positions
`define INTERNAL_DISPLAY_TABLE_OFF_BIT 0
`define AUX_AUDIO_BIT 1
`define REMOTE_DISPLAY_ID_COPY_BIT 5
`define OUTSIDE_CONTROLLER_BIT 7
`define CABLE_TYPE_BIT 7
`define PLL_RESET_ON_FREQ_CHANGE_BIT 5

// remote table bus address default and its register
`define REMOTE_ID_ADDR_REG 8'h60
`define REMOTE_ID_ADDR_RESET 8'ha0

// reset values of non-strap bits
`define DISPLAY_ID_CONTROL_RESET 8'h00
`define VIDEO_BRIDGE_CONFIG_RESET 8'h00
`define LINK_CONTROL_ONE_RESET 8'h20

// level decode thresholds on an 8-bit ratio code (full scale 8'hff)
`define MODE0_TH1 8'h1b
`define MODE0_TH2 8'h62
`define MODE0_TH3 8'h9b
`define MODE1_TH1 8'h1b
`define MODE1_TH2 8'h43
`define MODE1_TH3 8'h61
`define MODE1_TH4 8'h7f
`define MODE1_TH5 8'h9c
`define MODE1_TH6 8'hb9
`define MODE1_TH7 8'he4

// pixel clock limits in mhz
`define PCLK_MAX_MHZ 8'h60
`define PCLK_LEGACY_MAX_MHZ 8'h55

// settle time before strap capture, ns, and cycles at 5 ns
`define STRAP_SETTLE_NS 100
`define STRAP_SETTLE_CYCLES 8'h14

`endif

// File: verilog/strap_sync.v
/*
  two flip-flop synchroniser for an 8-bit strap level code.
  assumes the code is quasi-static around power-up.
*/
`timescale 1ns/1ps
module strap_sync (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // level in and out
  input wire [7:0] level_in,
  output reg [7:0] level_out
);
  reg [7:0] meta_q;
  always @(posedge sys_clk) begin
    if (rst) begin
      meta_q <= 8'h00;
      level_out <= 8'h00;
    end else begin
      meta_q <= level_in;
      level_out <= meta_q;
    end
  end
endmodule // strap_sync

// File: verilog/level_decoder.v
/*
  compares a ratio code against ascending thresholds and returns the level index.
  assumes thresholds are given in ascending order, unused ones at 8'hff.
*/
`timescale 1ns/1ps
module level_decoder (
  // ratio code
  input wire [7:0] code,
  // ascending thresholds, low byte first
  input wire [55:0] thresholds,
  // level index
  output reg [2:0] level
);
  integer i;
  always @* begin
    level = 3'h0;
    for (i = 0; i < 7; i = i + 1) begin
      if (code >= thresholds[i*8 +: 8]) begin
        level = level + 3'h1;
      end
    end
  end
endmodule // level_decoder

// File: verilog/strap_mode_config_latch.v
/*
  power-up strap capture into configuration registers, with a byte register port
  for the host and decoded control outputs for the datapaths.
  assumes the two strap pins arrive as 8-bit ratio codes from an on-chip converter,
  and that a control bus front end presents byte reads and writes on the register port.
*/
// Notes on behaviour
// - at power-up sample both strap inputs and capture decoded bits into registers.
// - every strap-derived register bit stays readable and writable by the host; the strap-derived device address is not.
// - source 0 tries remote display table first, falls back to internal copy.
// - source 1 takes display table from external local memory.
// - remote table bus address defaults to 0xa0, host may replace it.
// - aux audio 0 forwards main audio only; 1 adds auxiliary serial audio.
// - controller override 1 hands input port control to external controller.
// - cable select 0 means twisted pair, 1 means cable_type_select.
// - copy bit 1 loads remote table into sram when available; 0 keeps sram.
// - first strap decodes four levels into source and aux audio bits.
// - second strap decodes eight levels into override, cable, copy bits.
// - source bit lives at 0x4f bit 0.
// - aux audio bit lives at 0x54 bit 1.
// - controller override bit lives at 0x54 bit 7.
// - cable select bit lives at 0x5b bit 7.
// - remote copy bit lives at 0x54 bit 5.
// - pll reset on frequency change allowed only while its enable is set.
// - flag pixel clocks above 96 mhz, or at 85 mhz and above for older receivers.
// - answer on one of eight device addresses chosen by the address strap.
`timescale 1ns/1ps
`include "strap_config_defines.vh"
module strap_mode_config_latch (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // strap ratio codes from the pins
  input wire [7:0] mode_strap0_code,
  input wire [7:0] mode_strap1_code,
  input wire [7:0] address_select_pin,
  // register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  // control bus address
  output reg [6:0] device_address,
  // display table control
  output reg use_external_table,
  output reg try_remote_table,
  output reg copy_remote_to_sram,
  output reg [7:0] remote_table_addr,
  input wire remote_table_present,
  output reg use_sram_table,
  // audio, port control, cable
  output reg aux_audio_forward,
  output reg external_port_control,
  output reg cable_type_bit,
  // pll supervision
  input wire freq_change_seen,
  output reg pll_reset,
  input wire [7:0] pclk_mhz,
  input wire legacy_receiver,
  output reg pclk_over_limit,
  // capture done
  output reg straps_captured
);
  localparam [2:0] st_settle = 3'b001;
  localparam [2:0] st_capture = 3'b010;
  localparam [2:0] st_run = 3'b100;
  localparam [7:0] settle_cycles = `STRAP_SETTLE_CYCLES;

  reg [2:0] state_q;
  reg [7:0] settle_q;
  reg [7:0] id_ctl_q;
  reg [7:0] bridge_cfg_q;
  reg [7:0] link_ctl_q;
  reg [7:0] remote_addr_q;
  wire [7:0] s0_code;
  wire [7:0] s1_code;
  wire [7:0] id_code;
  wire [2:0] s0_level;
  wire [2:0] s1_level;
  wire [2:0] id_level;
  reg [1:0] s0_bits;

  strap_sync u_sync0 (.sys_clk(sys_clk), .rst(rst), .level_in(mode_strap0_code), .level_out(s0_code));
  strap_sync u_sync1 (.sys_clk(sys_clk), .rst(rst), .level_in(mode_strap1_code), .level_out(s1_code));
  strap_sync u_sync2 (.sys_clk(sys_clk), .rst(rst), .level_in(address_select_pin), .level_out(id_code));

  level_decoder u_dec0 (
    .code(s0_code),
    .thresholds({8'hff, 8'hff, 8'hff, 8'hff, `MODE0_TH3, `MODE0_TH2, `MODE0_TH1}),
    .level(s0_level)
  );
  level_decoder u_dec1 (
    .code(s1_code),
    .thresholds({`MODE1_TH7, `MODE1_TH6, `MODE1_TH5, `MODE1_TH4, `MODE1_TH3, `MODE1_TH2, `MODE1_TH1}),
    .level(s1_level)
  );
  level_decoder u_dec2 (
    .code(id_code),
    .thresholds({`MODE1_TH7, `MODE1_TH6, `MODE1_TH5, `MODE1_TH4, `MODE1_TH3, `MODE1_TH2, `MODE1_TH1}),
    .level(id_level)
  );

  // four levels map straight to two bits
  always @* begin
    s0_bits = s0_level[1:0];
  end

  // capture sequence and register file
  always @(posedge sys_clk) begin
    if (rst) begin
      state_q <= st_settle;
      settle_q <= 8'h00;
      id_ctl_q <= `DISPLAY_ID_CONTROL_RESET;
      bridge_cfg_q <= `VIDEO_BRIDGE_CONFIG_RESET;
      link_ctl_q <= `LINK_CONTROL_ONE_RESET;
      remote_addr_q <= `REMOTE_ID_ADDR_RESET;
      device_address <= 7'h00;
      straps_captured <= 1'b0;
    end else begin
      case (state_q)
        st_settle: begin
          settle_q <= settle_q + 8'h01;
          if (settle_q == settle_cycles - 8'h01) begin
            state_q <= st_capture;
          end
        end
        st_capture: begin
          id_ctl_q[`INTERNAL_DISPLAY_TABLE_OFF_BIT] <= s0_bits[1];
          bridge_cfg_q[`AUX_AUDIO_BIT] <= s0_bits[0];
          bridge_cfg_q[`OUTSIDE_CONTROLLER_BIT] <= s1_level[2];
          link_ctl_q[`CABLE_TYPE_BIT] <= s1_level[1];
          bridge_cfg_q[`REMOTE_DISPLAY_ID_COPY_BIT] <= s1_level[0];
          device_address <= {3'h0, id_level, 1'b0} + 7'h0c;
          straps_captured <= 1'b1;
          state_q <= st_run;
        end
        st_run: begin
          if (reg_wr) begin
            case (reg_addr)
              `DISPLAY_ID_CONTROL_REG: id_ctl_q <= reg_wdata;
              `VIDEO_BRIDGE_CONFIG_REG: bridge_cfg_q <= reg_wdata;
              `LINK_CONTROL_ONE_REG: link_ctl_q <= reg_wdata;
              `REMOTE_ID_ADDR_REG: remote_addr_q <= reg_wdata;
              default: begin
              end
            endcase
          end
        end
        default: state_q <= st_settle;
      endcase
    end
  end

  // register reads, one cycle after the request
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `DISPLAY_ID_CONTROL_REG: reg_rdata <= id_ctl_q;
          `VIDEO_BRIDGE_CONFIG_REG: reg_rdata <= bridge_cfg_q;
          `LINK_CONTROL_ONE_REG: reg_rdata <= link_ctl_q;
          `REMOTE_ID_ADDR_REG: reg_rdata <= remote_addr_q;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // decoded controls
  always @(posedge sys_clk) begin
    if (rst) begin
      use_external_table <= 1'b0;
      try_remote_table <= 1'b0;
      copy_remote_to_sram <= 1'b0;
      use_sram_table <= 1'b0;
      remote_table_addr <= `REMOTE_ID_ADDR_RESET;
      aux_audio_forward <= 1'b0;
      external_port_control <= 1'b0;
      cable_type_bit <= 1'b0;
      pll_reset <= 1'b0;
      pclk_over_limit <= 1'b0;
    end else begin
      use_external_table <= id_ctl_q[`INTERNAL_DISPLAY_TABLE_OFF_BIT];
      try_remote_table <= ~id_ctl_q[`INTERNAL_DISPLAY_TABLE_OFF_BIT];
      use_sram_table <= ~id_ctl_q[`INTERNAL_DISPLAY_TABLE_OFF_BIT] & ~remote_table_present;
      copy_remote_to_sram <= bridge_cfg_q[`REMOTE_DISPLAY_ID_COPY_BIT] & remote_table_present;
      remote_table_addr <= remote_addr_q;
      aux_audio_forward <= bridge_cfg_q[`AUX_AUDIO_BIT];
      external_port_control <= bridge_cfg_q[`OUTSIDE_CONTROLLER_BIT];
      cable_type_bit <= link_ctl_q[`CABLE_TYPE_BIT];
      pll_reset <= freq_change_seen & link_ctl_q[`PLL_RESET_ON_FREQ_CHANGE_BIT];
      pclk_over_limit <= legacy_receiver ? (pclk_mhz >= `PCLK_LEGACY_MAX_MHZ)
                                         : (pclk_mhz > `PCLK_MAX_MHZ);
    end
  end
endmodule // strap_mode_config_latch

// File: verif/strap_mode_config_latch_monitor.sv
/* port checker for the strap configuration latch.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module strap_mode_config_latch_monitor (
  input wire sys_clk,
  input wire rst,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  input wire [6:0] device_address,
  input wire use_external_table,
  input wire try_remote_table,
  input wire [7:0] remote_table_addr,
  input wire freq_change_seen,
  input wire pll_reset,
  input wire [7:0] pclk_mhz,
  input wire legacy_receiver,
  input wire pclk_over_limit,
  input wire straps_captured
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  chk_rvalid_cause: assert property (!$past(reg_rd) |-> !reg_rvalid) else $error("stray read valid");
  chk_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("read data moved");
  chk_pll_cause: assert property (!$past(freq_change_seen) |-> !pll_reset) else $error("pll reset uncaused");
  chk_capture_time: assert property ($fell(rst) |-> !straps_captured ##[1:30] straps_captured)
    else $error("capture late");
  chk_capture_keep: assert property (straps_captured |=> straps_captured) else $error("capture lost");
  chk_id_addr: assert property (straps_captured |-> device_address inside {[7'h0c:7'h1a]} && !device_address[0])
    else $error("bad device address");
  chk_remote_dflt: assert property ($fell(rst) |-> remote_table_addr == 8'ha0) else $error("remote addr default");
  chk_table_src: assert property (straps_captured |-> try_remote_table == !use_external_table)
    else $error("table source clash");
  chk_pclk_limit: assert property (!$past(rst) |-> pclk_over_limit == ($past(pclk_mhz) > 8'h60 ||
    ($past(legacy_receiver) && $past(pclk_mhz) >= 8'h55))) else $error("pclk limit flag");
endmodule // strap_mode_config_latch_monitor
bind strap_mode_config_latch strap_mode_config_latch_monitor mon (.sys_clk(sys_clk), .rst(rst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .device_address(device_address),
  .use_external_table(use_external_table), .try_remote_table(try_remote_table),
  .remote_table_addr(remote_table_addr), .freq_change_seen(freq_change_seen), .pll_reset(pll_reset),
  .pclk_mhz(pclk_mhz), .legacy_receiver(legacy_receiver), .pclk_over_limit(pclk_over_limit),
  .straps_captured(straps_captured));

// File: verif/host_ctrl_model.sv
/* host controller model on the byte register port.
   assumes strobes sampled at rising edges, read data one cycle later. */
`timescale 1ns/1ps
module host_ctrl_model (
  // clock
  input wire sys_clk,
  // register port
  output reg reg_wr = 1'b0,
  output reg reg_rd = 1'b0,
  output reg [7:0] reg_addr = 8'h00,
  output reg [7:0] reg_wdata = 8'h00,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid
);
  task wr(input [7:0] a, input [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task rd(input [7:0] a, output [7:0] d, output v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    v = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule // host_ctrl_model

// File: verif/test_strap_mode_config_latch.sv
/* random strap and register test of the strap configuration latch.
   assumes the host model on the register port and the bound checker. */
`timescale 1ns/1ps
`define CMP(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module test_strap_mode_config_latch;
  reg sys_clk = 1'b0, rst = 1'b1, freq = 1'b0, legacy = 1'b0, pres = 1'b0;
  reg [7:0] s0 = 8'h00, s1 = 8'h00, sa = 8'h00, pclk = 8'h00, d, w;
  reg v;
  wire wr, rd, rv, ext_t, try_t, copy_t, sram_t, aux, extc, cable_type_select, pllr, over, capt;
  wire [7:0] addr, wdata, rdata, raddr;
  wire [6:0] dev;
  int n_mismatch = 0, checked = 0, cyc = 0, l0, l1, la, k;
  logic [7:0] c8 [8] = '{8'h00, 8'h35, 8'h52, 8'h70, 8'h8d, 8'haa, 8'hc9, 8'hff};
  logic [7:0] pc [4] = '{8'h60, 8'h55, 8'h61, 8'h54};
  logic [7:0] ra [4] = '{8'h4f, 8'h54, 8'h5b, 8'h70};
  always #2.5 sys_clk = ~sys_clk;
  host_ctrl_model host (.sys_clk(sys_clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rvalid(rv));
  strap_mode_config_latch dut (.sys_clk(sys_clk), .rst(rst), .mode_strap0_code(s0), .mode_strap1_code(s1),
    .address_select_pin(sa), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rvalid(rv), .device_address(dev), .use_external_table(ext_t), .try_remote_table(try_t),
    .copy_remote_to_sram(copy_t), .remote_table_addr(raddr), .remote_table_present(pres),
    .use_sram_table(sram_t), .aux_audio_forward(aux), .external_port_control(extc), .cable_type_bit(cable_type_select),
    .freq_change_seen(freq), .pll_reset(pllr), .pclk_mhz(pclk), .legacy_receiver(legacy),
    .pclk_over_limit(over), .straps_captured(capt));
  function [7:0] exp_reg(input [7:0] a, input int p, input int q);
    exp_reg = (a == 8'h4f) ? {7'h00, p[1]} : (a == 8'h54) ? {q[2], 1'b0, q[0], 3'h0, p[0], 1'b0} :
      (a == 8'h5b) ? {q[1], 2'h1, 5'h00} : 8'h00;
  endfunction
  task give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  initial begin
    void'($urandom(37));
    for (int i = 0; i < 8; i++) begin
      l0 = (i < 2) ? 3 * i : $urandom % 4;
      l1 = (i < 2) ? 7 * i : $urandom % 8;
      la = $urandom % 8;
      @(posedge sys_clk);
      rst <= 1'b1;
      s0 <= c8[l0 < 2 ? l0 : l0 + 2];
      s1 <= c8[l1];
      sa <= c8[la];
      pclk <= pc[i % 4];
      legacy <= i[0];
      pres <= 1'($urandom % 2);
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      host.wr(8'h54, 8'h5a);
      for (k = 0; k < 40 && capt !== 1'b1; k++) @(posedge sys_clk);
      `CMP(capt, 1'b1)
      foreach (ra[j]) begin
        host.rd(ra[j], d, v);
        `CMP({v, d}, {1'b1, exp_reg(ra[j], l0, l1)})
      end
      `CMP({dev, ext_t, aux, extc, cable_type_select, copy_t}, {7'(8'h0c + 2 * la), l0[1], l0[0], l1[2], l1[1], l1[0] & pres})
      `CMP({try_t, sram_t}, {!l0[1], !l0[1] && !pres})
      `CMP({raddr, over}, {8'ha0, pc[i % 4] > 8'h60 || (i[0] && pc[i % 4] >= 8'h55)})
      w = $urandom;
      host.wr(8'h54, w);
      host.wr(8'h60, ~w);
      host.rd(8'h54, d, v);
      `CMP(d, w)
      `CMP({aux, extc, raddr}, {w[1], w[7], ~w})
      freq <= 1'b1;
      repeat (2) @(posedge sys_clk);
      `CMP(pllr, 1'b1)
      host.wr(8'h5b, 8'h00);
      repeat (2) @(posedge sys_clk);
      `CMP(pllr, 1'b0)
      freq <= 1'b0;
    end
    give_verdict;
  end
endmodule // test_strap_mode_config_latch
